// >>> src/edlt_pkg.sv
// Constants and types shared by the external data link tap
package edlt_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_SLOT_SELECT = 6'h15;
  localparam logic [5:0] IDX_BIT_MASK = 6'h16;
  localparam logic [5:0] IDX_LINK_CTRL = 6'h30;
  localparam logic [5:0] IDX_LINK_STATUS = 6'h31;

  // Reset values
  localparam logic [7:0] SLOT_SELECT_RST = 8'h00;
  localparam logic [7:0] BIT_MASK_RST = 8'h00;
  localparam logic [7:0] LINK_CTRL_RST = 8'h00;

  // Field positions in link_slot_select
  localparam int unsigned POS_LINK_ENABLE = 7;
  localparam int unsigned POS_FS_HI = 6;
  localparam int unsigned POS_FS_LO = 5;
  localparam int unsigned POS_TS_HI = 4;
  localparam int unsigned POS_TS_LO = 0;

  // Field positions in link_ctrl
  localparam int unsigned POS_T1_MODE = 0;
  localparam int unsigned POS_RX_PIN_SEL = 1;
  localparam int unsigned POS_TX_PIN_SEL = 2;

  // Frame select codes
  localparam logic [1:0] FS_NONE = 2'h0;
  localparam logic [1:0] FS_CODE_01 = 2'h1;
  localparam logic [1:0] FS_CODE_10 = 2'h2;
  localparam logic [1:0] FS_ALL = 2'h3;

  // Frame geometry
  localparam logic [4:0] T1_FBIT_SLOT = 5'h19;
  localparam logic [8:0] T1_SLOT_BASE_ADJ = 9'h007;
  localparam logic [8:0] BITS_PER_SLOT = 9'h008;
  localparam logic [8:0] POS_FIRST = 9'h000;
  localparam logic [8:0] POS_STEP = 9'h001;

  // Transmit capture path
  localparam int unsigned TX_SAMPLE_DELAY = 2;
  localparam int unsigned BUF_DEPTH = 2;
  localparam int unsigned BUF_WIDTH = 1;

  typedef enum logic [0:0] {
    EDLT_BUS_IDLE = 1'b0,
    EDLT_BUS_ACK = 1'b1
  } edlt_bus_state_t;

endpackage

// >>> src/edlt_slot_gate.sv
// One direction of link timing: synchroniser, bit position, slot gate
module edlt_slot_gate
  import edlt_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic line_clk,
  input wire logic frame_start,
  input wire logic mframe_start,
  input wire logic line_data,
  input wire logic t1_mode,
  input wire logic [4:0] slot_number,
  input wire logic [1:0] frame_select,
  input wire logic [7:0] bit_mask,
  output logic clk_level,
  output logic bit_rise,
  output logic bit_selected,
  output logic frame_odd,
  output logic data_bit
);

  logic [2:0] clk_sync;
  logic [1:0] fs_sync;
  logic [1:0] mf_sync;
  logic [1:0] dat_sync;
  logic [8:0] bit_pos;
  logic [8:0] slot_base;
  logic [8:0] slot_off;
  logic t1_fbit;
  logic in_slot;
  logic frame_ok;
  logic frame_par;

  // Third clock stage feeds edge detection and clk_level, never the first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_sync <= 3'h0;
      fs_sync <= 2'h0;
      mf_sync <= 2'h0;
      dat_sync <= 2'h0;
    end else begin
      clk_sync <= {clk_sync[1:0], line_clk};
      fs_sync <= {fs_sync[0], frame_start};
      mf_sync <= {mf_sync[0], mframe_start};
      dat_sync <= {dat_sync[0], line_data};
    end
  end

  assign bit_rise = clk_sync[1] & ~clk_sync[2];
  assign clk_level = clk_sync[2];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_pos <= POS_FIRST;
    end else if (bit_rise) begin
      bit_pos <= fs_sync[1] ? POS_FIRST : bit_pos + POS_STEP;
    end
  end

  // Parity of the frame index since multiframe start, free of mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_par <= 1'b0;
    end else if (bit_rise && fs_sync[1]) begin
      frame_par <= mf_sync[1] ? 1'b0 : ~frame_par;
    end
  end

  // Multiframe start names frame 1 in T1 and frame 0 in E1
  // Derived per mode so a mode change needs no fresh multiframe mark
  assign frame_odd = frame_par ^ t1_mode;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_bit <= 1'b0;
    end else if (bit_rise) begin
      data_bit <= dat_sync[1];
    end
  end

  always_comb begin
    t1_fbit = t1_mode && (slot_number == T1_FBIT_SLOT);
    slot_base = {1'b0, slot_number, 3'h0};
    // Framing bit sits at position 0, so it uses mask bit 0
    if (t1_fbit) begin
      slot_base = POS_FIRST;
    end else if (t1_mode) begin
      slot_base = slot_base - T1_SLOT_BASE_ADJ;
    end
    slot_off = bit_pos - slot_base;
    in_slot = t1_fbit ? (bit_pos == POS_FIRST) : (slot_off < BITS_PER_SLOT);
  end

  // Code 01 picks odd frames in T1 and even frames in E1
  always_comb begin
    unique case (frame_select)
      FS_NONE: frame_ok = 1'b0;
      FS_CODE_01: frame_ok = (frame_odd == t1_mode);
      FS_CODE_10: frame_ok = (frame_odd != t1_mode);
      FS_ALL: frame_ok = 1'b1;
    endcase
  end

  // Mask bit 0 is the first bit of the slot on the wire
  assign bit_selected = in_slot & frame_ok
                        & bit_mask[slot_off[2:0]];
endmodule

// >>> src/edlt_tap.sv
// External data link tap: registers, gated link clocks, transmit capture
// Function
// - Link enable 0 keeps link pins idle; 1 activates each direction whose pin select is on unless frame select is 00.
// - Frame select: 00 none, 11 all, 01/10 odd/even per mode.
// - Frame select gates both receive and transmit link clocks.
// - Binary slot number picks one eight-bit slot, E1 0-31, T1 1-24.
// - In T1, slot number 25 selects the framing bit.
// - Clock pulses appear only on slot bits whose mask bit is one.
// - Mask bit zero maps to first slot bit, higher bits follow.
// - With receive pin select on, whole received stream goes out.
// - Transmit bits sampled at link clock fall, replacing normal data.
module edlt_tap
  import edlt_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rx_line_clk,
  input wire logic rx_line_data,
  input wire logic rx_frame_start,
  input wire logic rx_mframe_start,
  input wire logic tx_line_clk,
  input wire logic tx_frame_start,
  input wire logic tx_mframe_start,
  input wire logic tx_link_data_in,
  output logic rx_link_clock_out,
  output logic rx_link_data_out,
  output logic rx_link_oe,
  output logic tx_link_clock_out,
  output logic tx_link_oe,
  output logic tx_ins_valid,
  output logic tx_ins_bit,
  input wire logic tx_ins_ready
);

  edlt_bus_state_t bus_state;
  logic [7:0] link_slot_select;
  logic [7:0] link_bit_mask;
  logic [7:0] link_ctrl;
  logic [5:0] reg_index;
  logic [7:0] read_mux;
  logic wr_take;

  logic link_enable;
  logic [1:0] frame_select;
  logic [4:0] slot_number;
  logic t1_mode;
  logic rx_active;
  logic tx_active;

  logic rx_level;
  logic rx_rise;
  logic rx_sel;
  logic rx_frame_odd;
  logic rx_bit;
  logic tx_level;
  logic tx_rise;
  logic tx_sel;
  logic tx_frame_odd;

  logic [1:0] tdi_sync;
  logic [TX_SAMPLE_DELAY-1:0] fall_dly;
  logic next_tx_clock;
  logic tx_fall;
  logic tx_allow;
  logic room_ok;
  logic push;
  logic pop;
  logic [BUF_WIDTH-1:0] spare_bit;
  logic spare_valid;

  assign reg_index = avs_address[7:2];
  assign link_enable = link_slot_select[POS_LINK_ENABLE];
  assign frame_select = link_slot_select[POS_FS_HI:POS_FS_LO];
  assign slot_number = link_slot_select[POS_TS_HI:POS_TS_LO];
  assign t1_mode = link_ctrl[POS_T1_MODE];

  // Frame select 00 acts like a disabled link on both directions
  assign rx_active = link_enable && (frame_select != FS_NONE)
                     && link_ctrl[POS_RX_PIN_SEL];
  assign tx_active = link_enable && (frame_select != FS_NONE)
                     && link_ctrl[POS_TX_PIN_SEL];

  // Bus slave: one wait cycle, answer on the second cycle of a request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_state <= EDLT_BUS_IDLE;
      avs_waitrequest <= 1'b1;
    end else begin
      unique case (bus_state)
        EDLT_BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_state <= EDLT_BUS_ACK;
            avs_waitrequest <= 1'b0;
          end
        end
        EDLT_BUS_ACK: begin
          bus_state <= EDLT_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  assign wr_take = (bus_state == EDLT_BUS_ACK) && avs_write
                   && avs_byteenable[0];

  always_comb begin
    unique case (reg_index)
      IDX_SLOT_SELECT: read_mux = link_slot_select;
      IDX_BIT_MASK: read_mux = link_bit_mask;
      IDX_LINK_CTRL: read_mux = link_ctrl;
      IDX_LINK_STATUS: read_mux = {2'h0, tx_link_clock_out,
                                   rx_link_clock_out, spare_valid,
                                   tx_ins_valid, tx_frame_odd,
                                   rx_frame_odd};
      default: read_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (bus_state == EDLT_BUS_IDLE && avs_read) begin
      avs_readdata <= {24'h00_0000, read_mux};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link_slot_select <= SLOT_SELECT_RST;
      link_bit_mask <= BIT_MASK_RST;
      link_ctrl <= LINK_CTRL_RST;
    end else if (wr_take) begin
      if (reg_index == IDX_SLOT_SELECT) begin
        link_slot_select <= avs_writedata[7:0];
      end
      if (reg_index == IDX_BIT_MASK) begin
        link_bit_mask <= avs_writedata[7:0];
      end
      if (reg_index == IDX_LINK_CTRL) begin
        link_ctrl <= {5'h00, avs_writedata[2:0]};
      end
    end
  end

  edlt_slot_gate u_rx_gate (
    .clk(clk),
    .rst_n(rst_n),
    .line_clk(rx_line_clk),
    .frame_start(rx_frame_start),
    .mframe_start(rx_mframe_start),
    .line_data(rx_line_data),
    .t1_mode(t1_mode),
    .slot_number(slot_number),
    .frame_select(frame_select),
    .bit_mask(link_bit_mask),
    .clk_level(rx_level),
    .bit_rise(rx_rise),
    .bit_selected(rx_sel),
    .frame_odd(rx_frame_odd),
    .data_bit(rx_bit)
  );

  // Transmit data comes from the tap pin, not this gate
  edlt_slot_gate u_tx_gate (
    .clk(clk),
    .rst_n(rst_n),
    .line_clk(tx_line_clk),
    .frame_start(tx_frame_start),
    .mframe_start(tx_mframe_start),
    .line_data(1'b0),
    .t1_mode(t1_mode),
    .slot_number(slot_number),
    .frame_select(frame_select),
    .bit_mask(link_bit_mask),
    .clk_level(tx_level),
    .bit_rise(tx_rise),
    .bit_selected(tx_sel),
    .frame_odd(tx_frame_odd),
    .data_bit()
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_link_oe <= 1'b0;
      tx_link_oe <= 1'b0;
    end else begin
      rx_link_oe <= rx_active;
      tx_link_oe <= tx_active;
    end
  end

  // Whole received stream, whatever bits carry a clock pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_link_data_out <= 1'b0;
    end else begin
      rx_link_data_out <= rx_active & rx_bit;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_link_clock_out <= 1'b0;
    end else begin
      rx_link_clock_out <= rx_active & rx_sel
                           & rx_level;
    end
  end

  // Room decided once per bit so a pulse is never chopped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_allow <= 1'b0;
    end else if (tx_rise) begin
      tx_allow <= room_ok;
    end
  end

  assign next_tx_clock = tx_active & tx_sel & tx_allow & tx_level;
  assign tx_fall = tx_link_clock_out & ~next_tx_clock;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_link_clock_out <= 1'b0;
    end else begin
      tx_link_clock_out <= next_tx_clock;
    end
  end

  // Pin data lags two cycles, so the fall is delayed to match
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tdi_sync <= 2'h0;
      fall_dly <= '0;
    end else begin
      tdi_sync <= {tdi_sync[0], tx_link_data_in};
      fall_dly <= {fall_dly[TX_SAMPLE_DELAY-2:0], tx_fall};
    end
  end

  // Two-entry buffer: output head plus one spare entry
  assign push = fall_dly[TX_SAMPLE_DELAY-1];
  assign pop = tx_ins_valid & tx_ins_ready;
  assign room_ok = !spare_valid && !(tx_ins_valid && (|fall_dly));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_ins_valid <= 1'b0;
      tx_ins_bit <= 1'b0;
      spare_valid <= 1'b0;
      spare_bit <= '0;
    end else if (push) begin
      if (!tx_ins_valid || (pop && !spare_valid)) begin
        tx_ins_valid <= 1'b1;
        tx_ins_bit <= tdi_sync[1];
      end else if (pop) begin
        tx_ins_bit <= spare_bit[0];
        spare_bit <= tdi_sync[1];
      end else begin
        spare_valid <= 1'b1;
        spare_bit <= tdi_sync[1];
      end
    end else if (pop) begin
      if (spare_valid) begin
        tx_ins_bit <= spare_bit[0];
        spare_valid <= 1'b0;
      end else begin
        tx_ins_valid <= 1'b0;
      end
    end
  end
endmodule

// >>> test/edlt_tap_chk.sv
// Port checks for the external data link tap
module edlt_tap_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic rx_link_clock_out,
  input wire logic rx_link_data_out,
  input wire logic rx_link_oe,
  input wire logic tx_link_clock_out,
  input wire logic tx_link_oe,
  input wire logic tx_ins_valid,
  input wire logic tx_ins_bit,
  input wire logic tx_ins_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  // Counts idle cycles; a pulse already launched may finish first
  logic [4:0] rx_off;
  logic [4:0] tx_off;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_off <= 5'h00;
      tx_off <= 5'h00;
    end else begin
      rx_off <= rx_link_oe ? 5'h00 : rx_off + {4'h0, rx_off != 5'h10};
      tx_off <= tx_link_oe ? 5'h00 : tx_off + {4'h0, tx_off != 5'h10};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence bus_req; $rose(avs_read || avs_write); endsequence
  sequence bus_ack; !avs_waitrequest ##1 avs_waitrequest; endsequence
  sequence tx_fall; tx_link_clock_out ##1 !tx_link_clock_out; endsequence
  bus_answer_a: assert property (bus_req |=> bus_ack)
    else $error("bus answer wrong");
  rx_idle_a: assert property (
    rx_off == 5'h10 |-> !rx_link_clock_out)
    else $error("rx clock while idle");
  tx_idle_a: assert property (
    tx_off == 5'h10 |-> !tx_link_clock_out)
    else $error("tx clock while idle");
  rx_data_idle_a: assert property (
    rx_off == 5'h10 |-> !rx_link_data_out)
    else $error("rx data while idle");
  rx_width_a: assert property (
    $rose(rx_link_clock_out) |-> rx_link_clock_out[*8])
    else $error("rx pulse short");
  tx_width_a: assert property (
    $rose(tx_link_clock_out) |-> tx_link_clock_out[*8])
    else $error("tx pulse short");
  rx_data_hold_a: assert property (
    rx_link_clock_out && $past(rx_link_clock_out, 2)
    && $past(rx_link_clock_out) |-> $stable(rx_link_data_out))
    else $error("rx data moved in pulse");
  tx_capture_a: assert property (tx_fall |-> ##[1:4] tx_ins_valid)
    else $error("tx bit not captured");
  ins_hold_a: assert property (tx_ins_valid && !tx_ins_ready
    |=> tx_ins_valid && $stable(tx_ins_bit))
    else $error("captured bit lost");
endmodule
bind edlt_tap edlt_tap_chk u_chk (.clk(clk), .rst_n(rst_n),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .rx_link_clock_out(rx_link_clock_out),
  .rx_link_data_out(rx_link_data_out), .rx_link_oe(rx_link_oe),
  .tx_link_clock_out(tx_link_clock_out), .tx_link_oe(tx_link_oe),
  .tx_ins_valid(tx_ins_valid), .tx_ins_bit(tx_ins_bit),
  .tx_ins_ready(tx_ins_ready));

// >>> test/edlt_link_partner.sv
// Framer timing source and far-end link controller model
module edlt_link_partner #(
  parameter int FRAME_BITS = 40
) (
  input wire logic clk,
  output logic line_clk = 1'b0,
  output logic frame_start = 1'b0,
  output logic mframe_start = 1'b0,
  output logic line_data = 1'b0,
  output logic link_data_in = 1'b0,
  input wire logic rx_clk_out,
  input wire logic rx_data_out,
  input wire logic tx_clk_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int ph = 0;
  int pos = 0;
  int fnum = 0;
  int hold = 0;
  int tseq = 0;
  int nxt;
  int nf;
  logic rxc_q = 1'b0;
  logic txc_q = 1'b0;
  int rx_pos_q[$];
  int tx_pos_q[$];
  logic rx_dat_q[$];
  logic rx_exp_q[$];
  logic tx_q[$];
  function automatic logic pat(input int p, input int f);
    return p[0] ^ p[2] ^ f[0];
  endfunction
  assign nxt = (pos == FRAME_BITS - 1) ? 0 : pos + 1;
  assign nf = fnum + int'(nxt == 0);
  always @(posedge clk) begin
    ph <= (ph == 19) ? 0 : ph + 1;
    rxc_q <= rx_clk_out;
    txc_q <= tx_clk_out;
    // Line clock 160 ns; data and frame marks move while it is low
    if (ph == 9) begin
      line_clk <= 1'b0;
      frame_start <= (nxt == 0);
      mframe_start <= (nxt == 0) && (nf % 4 == 0);
      line_data <= pat(nxt, nf);
    end
    if (ph == 19) begin
      line_clk <= 1'b1;
      pos <= nxt;
      fnum <= nf;
    end
    if (rxc_q && !rx_clk_out) begin
      rx_pos_q.push_back(pos);
      rx_dat_q.push_back(rx_data_out);
      rx_exp_q.push_back(pat(pos, fnum));
    end
    // Bit presented at pulse rise, before the sampling fall
    if (!txc_q && tx_clk_out) begin
      link_data_in <= tseq[0] ^ tseq[2];
      tseq <= tseq + 1;
    end
    if (txc_q && !tx_clk_out) begin
      tx_q.push_back(link_data_in);
      tx_pos_q.push_back(pos);
      hold <= 1;
    end else if (hold != 0) begin
      hold <= (hold == 6) ? 0 : hold + 1;
      // Stale bit inverted once its hold is over
      if (hold == 6) link_data_in <= !link_data_in;
    end
  end
endmodule

// >>> test/test_edlt_tap.sv
// Self-checking bench for the external data link tap
module test_edlt_tap;
  timeunit 1ns;
  timeprecision 1ns;
  import edlt_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic lclk, fst, mfst, ldat, tdi, rxc, rxd, rxoe, txc, txoe, ivalid, ibit;
  logic iready = 1'b1;
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  edlt_tap u_dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rx_line_clk(lclk), .rx_line_data(ldat), .rx_frame_start(fst),
    .rx_mframe_start(mfst), .tx_line_clk(lclk), .tx_frame_start(fst),
    .tx_mframe_start(mfst), .tx_link_data_in(tdi),
    .rx_link_clock_out(rxc), .rx_link_data_out(rxd), .rx_link_oe(rxoe),
    .tx_link_clock_out(txc), .tx_link_oe(txoe), .tx_ins_valid(ivalid),
    .tx_ins_bit(ibit), .tx_ins_ready(iready));
  edlt_link_partner u_partner (.clk(clk), .line_clk(lclk),
    .frame_start(fst), .mframe_start(mfst), .line_data(ldat),
    .link_data_in(tdi), .rx_clk_out(rxc), .rx_data_out(rxd),
    .tx_clk_out(txc));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Whole run needs about 32000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total++;
      report_and_stop();
    end
  end
  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [5:0] idx,
      input logic [3:0] be, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    avs_address <= {idx, 2'b00};
    avs_byteenable <= be;
    avs_writedata <= {24'h000000, d};
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic cfg(input logic [2:0] ctrl, input logic [7:0] sel,
      input logic [7:0] mask);
    logic [7:0] q;
    bus(1'b1, IDX_LINK_CTRL, 4'hF, {5'h00, ctrl}, q);
    bus(1'b1, IDX_SLOT_SELECT, 4'hF, sel, q);
    bus(1'b1, IDX_BIT_MASK, 4'hF, mask, q);
  endtask
  task automatic wait_frame();
    do @(posedge clk); while (!(u_partner.ph == 0 && u_partner.pos == 0));
  endtask
  task automatic clear_q();
    u_partner.rx_pos_q.delete();
    u_partner.rx_dat_q.delete();
    u_partner.rx_exp_q.delete();
    u_partner.tx_pos_q.delete();
    u_partner.tx_q.delete();
  endtask
  function automatic bit fsel(input bit t1, input logic [1:0] fs,
      input int lbl);
    case (fs)
      2'h0: return 1'b0;
      2'h3: return 1'b1;
      2'h1: return t1 ? lbl[0] : !lbl[0];
      default: return t1 ? !lbl[0] : lbl[0];
    endcase
  endfunction
  task automatic t_regs();
    logic [7:0] q;
    bus(1'b0, IDX_SLOT_SELECT, 4'hF, 8'h00, q);
    check("slot reset", q, SLOT_SELECT_RST);
    bus(1'b0, IDX_BIT_MASK, 4'hF, 8'h00, q);
    check("mask reset", q, BIT_MASK_RST);
    bus(1'b1, IDX_SLOT_SELECT, 4'hF, 8'h1B, q);
    bus(1'b1, IDX_BIT_MASK, 4'hF, 8'h3C, q);
    bus(1'b1, IDX_BIT_MASK, 4'hE, 8'hFF, q);
    bus(1'b0, IDX_SLOT_SELECT, 4'hF, 8'h00, q);
    check("slot rw", q, 8'h1B);
    bus(1'b0, IDX_BIT_MASK, 4'hF, 8'h00, q);
    check("mask rw", q, 8'h3C);
    bus(1'b1, 6'h3F, 4'hF, 8'hA5, q);
    bus(1'b0, 6'h3F, 4'hF, 8'h00, q);
    check("unmapped", q, 8'h00);
    $display("register test done");
  endtask
  task automatic t_frames();
    logic [1:0] fs;
    bit t1;
    bit en;
    int exp;
    for (int m = 0; m < 10; m++) begin
      t1 = m[0];
      en = (m < 8);
      fs = en ? m[2:1] : 2'h3;
      cfg({2'b11, t1}, {en, fs, 5'h02}, 8'h81);
      wait_frame();
      for (int f = 0; f < 2; f++) begin
        clear_q();
        exp = (en && fsel(t1, fs, u_partner.fnum + int'(t1))) ? 2 : 0;
        wait_frame();
        check("rx pulses", u_partner.rx_pos_q.size(), exp);
        check("tx pulses", u_partner.tx_pos_q.size(), exp);
      end
      if (fs != 2'h0) check("rx enable", rxoe, en);
      if (fs != 2'h0) check("tx enable", txoe, en);
    end
    $display("frame test done");
  endtask
  task automatic t_slot(input bit t1, input logic [4:0] ts,
      input logic [7:0] mask);
    int base;
    int n;
    base = t1 ? ((ts == 5'h19) ? 0 : 8 * ts - 7) : 8 * ts;
    n = 0;
    cfg({2'b11, t1}, {3'b111, ts}, mask);
    wait_frame();
    clear_q();
    wait_frame();
    for (int i = 0; i < 8; i++) begin
      if (mask[i]) begin
        check("rx bit", u_partner.rx_pos_q[n], base + i);
        check("tx bit", u_partner.tx_pos_q[n], base + i);
        check("rx data", u_partner.rx_dat_q[n],
          u_partner.rx_exp_q[n]);
        n++;
      end
    end
    check("pulse count", u_partner.rx_pos_q.size(), n);
    $display("slot test done");
  endtask
  task automatic t_stall();
    logic got[$];
    logic [7:0] q;
    int n;
    // Let a framing bit pulse from the last setup finish whole
    repeat (20) @(posedge clk);
    cfg(3'h6, 8'hE1, 8'hFF);
    wait_frame();
    iready <= 1'b0;
    clear_q();
    wait_frame();
    n = u_partner.tx_q.size();
    check("stall count", n, BUF_DEPTH);
    bus(1'b0, IDX_LINK_STATUS, 4'hF, 8'h00, q);
    check("buffer full", q & 8'h0C, 8'h0C);
    bus(1'b1, IDX_SLOT_SELECT, 4'hF, 8'h00, q);
    iready <= 1'b1;
    repeat (20) begin
      @(posedge clk);
      if (ivalid === 1'b1 && iready === 1'b1) got.push_back(ibit);
    end
    check("drained", got.size(), n);
    foreach (got[i]) check("captured", got[i], u_partner.tx_q[i]);
    $display("stall test done");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_frames();
    t_slot(1'b0, 5'h03, 8'h2C);
    t_slot(1'b0, 5'h04, 8'hA5);
    t_slot(1'b1, 5'h01, 8'h5A);
    t_slot(1'b1, 5'h19, 8'h01);
    t_stall();
    report_and_stop();
  end
endmodule
